// >>> src/rxdd_regs.vh
// Register offsets, descriptor field layout and reset values of the receive descriptor engine
`ifndef RXDD_REGS_VH
`define RXDD_REGS_VH
`define RXDD_OFF_CTRL 8'h00
`define RXDD_OFF_FIRST 8'h04
`define RXDD_OFF_CMD 8'h08
`define RXDD_OFF_STAT 8'h0C
`define RXDD_OFF_CUR 8'h10
`define RXDD_OFF_CCB 8'h14
`define RXDD_CTRL_RST 32'h0000_0003
`define RXDD_CMD_JUMP 0
`define RXDD_CMD_ABORT 1
`define RXDD_CMD_INIT 2
`define RXDD_MODE_TMA 2'h0
`define RXDD_MODE_TMB 2'h1
`define RXDD_MODE_RATE 2'h2
`define RXDD_MODE_HDLC 2'h3
`define RXDD_CW_HOLD 30
`define RXDD_CW_HI 29
`define RXDD_SIZE_HI 28
`define RXDD_SIZE_LO 16
`define RXDD_DW_FE 31
`define RXDD_DW_DONE 30
`define RXDD_STS_HI 15
`define RXDD_STS_LO 8
`define RXDD_STS_OK 8'h00
`define RXDD_STS_SHORT 8'h40
`define RXDD_STS_LONG 8'h04
`define RXDD_STS_ABORT 8'h02
`define RXDD_MASK_HDLC 8'h7F
`define RXDD_MASK_TMB 8'h0F
`define RXDD_MASK_RATE 8'h23
`define RXDD_MASK_TMA 8'h02
`define RXDD_DESC_STEP 32'h0000_0004
`define RXDD_MAX_FRAME 16'h0800
`endif

// >>> src/rxdd_engine.v
// Receive descriptor engine: descriptor fetch, data fill, completion write-back and stall polling
`timescale 1ns/1ns
`include "rxdd_regs.vh"
module rxdd_engine #(
  parameter MAX_FRAME = `RXDD_MAX_FRAME
) (
  input wire clk,
  input wire rst_b,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire mem_req,
  output wire mem_we,
  output wire [31:0] mem_addr,
  output wire [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire rx_valid,
  output wire rx_ready,
  input wire [31:0] rx_data,
  input wire [2:0] rx_nbytes,
  input wire rx_last,
  input wire rx_event,
  input wire [7:0] rx_status,
  output wire irq_valid,
  output wire irq_frame,
  output wire irq_err,
  output wire irq_host
);
  localparam S_IDLE = 12'h001;
  localparam S_RCTL = 12'h002;
  localparam S_RNXT = 12'h004;
  localparam S_RDAT = 12'h008;
  localparam S_WCUR = 12'h010;
  localparam S_DATA = 12'h020;
  localparam S_WDAT = 12'h040;
  localparam S_DONE = 12'h080;
  localparam S_IRQ = 12'h100;
  localparam S_PWAIT = 12'h200;
  localparam S_PCTL = 12'h400;
  localparam S_DISC = 12'h800;
  // Sized copies so address sums and the reset mode keep their widths on purpose
  localparam [31:0] CTRL_RST = `RXDD_CTRL_RST;
  localparam [31:0] STEP1 = `RXDD_DESC_STEP;
  localparam [31:0] STEP2 = {STEP1[30:0], 1'b0};
  localparam [31:0] STEP3 = STEP2 + STEP1;

  reg [11:0] state_ff, nxt_state;
  reg [1:0] mode_ff;
  reg [31:0] first_ff, ccb_ff, cur_ff, next_ff, dptr_ff;
  reg [31:0] nxt_first, nxt_ccb, nxt_cur, nxt_next, nxt_dptr;
  reg [31:0] addr_ff, wdata_ff, nxt_addr, nxt_wdata;
  reg we_ff, nxt_we;
  reg hold_ff, hi_ff, nxt_hold, nxt_hi;
  reg [12:0] size_ff, bno_ff, nxt_size, nxt_bno;
  reg [15:0] fcnt_ff, nxt_fcnt;
  reg fe_ff, nxt_fe, last_ff, nxt_last;
  reg [7:0] sts_ff, nxt_sts, fsts_ff, nxt_fsts;
  reg pend_fe_ff, nxt_pend_fe, skip_ff, nxt_skip, first_sel_ff, nxt_first_sel;
  reg [2:0] cmd_ff;
  reg [2:0] cmd_take;
  reg irq_ff, nxt_irq, ifr_ff, nxt_ifr, ier_ff, nxt_ier, iho_ff, nxt_iho;

  wire frame_mode = (mode_ff == `RXDD_MODE_HDLC) || (mode_ff == `RXDD_MODE_TMB);
  wire apb_wr = psel & penable & pwrite;
  wire hit = (paddr == `RXDD_OFF_CTRL) || (paddr == `RXDD_OFF_FIRST) ||
             (paddr == `RXDD_OFF_CMD) || (paddr == `RXDD_OFF_STAT) ||
             (paddr == `RXDD_OFF_CUR) || (paddr == `RXDD_OFF_CCB);
  wire [2:0] cmd_set = (apb_wr && paddr == `RXDD_OFF_CMD) ? pwdata[2:0] : 3'h0;
  wire rx_take = rx_valid & rx_ready;
  wire [12:0] bno_sum = bno_ff + {10'h000, rx_nbytes};
  wire [15:0] fcnt_sum = fcnt_ff + {13'h0000, rx_nbytes};

  reg [7:0] sts_mask;
  always @* begin
    case (mode_ff)
      `RXDD_MODE_HDLC: sts_mask = `RXDD_MASK_HDLC;
      `RXDD_MODE_TMB: sts_mask = `RXDD_MASK_TMB;
      `RXDD_MODE_RATE: sts_mask = `RXDD_MASK_RATE;
      default: sts_mask = `RXDD_MASK_TMA;
    endcase
  end

  // APB slave: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  always @* begin
    case (paddr)
      `RXDD_OFF_CTRL: prdata = {30'h0, mode_ff};
      `RXDD_OFF_FIRST: prdata = first_ff;
      `RXDD_OFF_STAT: prdata = {16'h0, 1'b0, hold_ff, pend_fe_ff, first_sel_ff, state_ff};
      `RXDD_OFF_CUR: prdata = cur_ff;
      `RXDD_OFF_CCB: prdata = ccb_ff;
      default: prdata = 32'h0;
    endcase
  end

  assign mem_req = (state_ff & (S_RCTL | S_RNXT | S_RDAT | S_WCUR | S_WDAT | S_DONE |
                    S_PCTL)) != 12'h000;
  assign mem_we = we_ff;
  assign mem_addr = addr_ff;
  assign mem_wdata = wdata_ff;
  // Stall wait and discard states keep draining the receiver; it only pauses while S_PCTL polls the control word
  assign rx_ready = (state_ff == S_DATA && cmd_ff == 3'h0 && !pend_fe_ff) ||
                    (state_ff == S_PWAIT) || (state_ff == S_DISC);
  assign irq_valid = irq_ff;
  assign irq_frame = ifr_ff;
  assign irq_err = ier_ff;
  assign irq_host = iho_ff;

  always @* begin
    nxt_state = state_ff;
    nxt_first = first_ff;
    nxt_ccb = ccb_ff;
    nxt_cur = cur_ff;
    nxt_next = next_ff;
    nxt_dptr = dptr_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_we = we_ff;
    nxt_hold = hold_ff;
    nxt_hi = hi_ff;
    nxt_size = size_ff;
    nxt_bno = bno_ff;
    nxt_fcnt = fcnt_ff;
    nxt_fe = fe_ff;
    nxt_last = last_ff;
    nxt_sts = sts_ff;
    nxt_fsts = fsts_ff;
    nxt_pend_fe = pend_fe_ff;
    nxt_skip = skip_ff;
    nxt_first_sel = first_sel_ff;
    cmd_take = 3'h0;
    nxt_irq = 1'b0;
    nxt_ifr = 1'b0;
    nxt_ier = 1'b0;
    nxt_iho = 1'b0;
    if (apb_wr && paddr == `RXDD_OFF_FIRST)
      nxt_first = pwdata;
    if (apb_wr && paddr == `RXDD_OFF_CCB)
      nxt_ccb = pwdata;
    case (state_ff)
      S_IDLE: begin
        if (cmd_ff != 3'h0) begin
          cmd_take = cmd_ff;
          nxt_cur = first_ff;
          nxt_addr = first_ff;
          nxt_we = 1'b0;
          nxt_pend_fe = 1'b0;
          nxt_state = S_RCTL;
        end
      end
      S_RCTL: begin
        if (mem_ack) begin
          nxt_hold = mem_rdata[`RXDD_CW_HOLD];
          nxt_hi = mem_rdata[`RXDD_CW_HI];
          nxt_size = mem_rdata[`RXDD_SIZE_HI:`RXDD_SIZE_LO];
          nxt_addr = cur_ff + `RXDD_DESC_STEP;
          nxt_state = S_RNXT;
        end
      end
      S_RNXT: begin
        if (mem_ack) begin
          nxt_next = mem_rdata;
          nxt_addr = cur_ff + STEP2;
          nxt_state = S_RDAT;
        end
      end
      S_RDAT: begin
        if (mem_ack) begin
          nxt_dptr = mem_rdata;
          nxt_addr = ccb_ff;
          nxt_wdata = cur_ff;
          nxt_we = 1'b1;
          nxt_bno = 13'h0000;
          nxt_state = S_WCUR;
        end
      end
      S_WCUR: begin
        if (mem_ack) begin
          nxt_we = 1'b0;
          nxt_state = S_DATA;
          if (pend_fe_ff) begin
            // Empty closing descriptor after an exactly filled one
            nxt_pend_fe = 1'b0;
            nxt_fe = 1'b1;
            nxt_sts = fsts_ff;
            nxt_state = S_DONE;
          end
        end
      end
      S_DATA: begin
        if (cmd_ff[`RXDD_CMD_INIT] || cmd_ff[`RXDD_CMD_JUMP]) begin
          cmd_take = cmd_ff & 3'h5;
          nxt_cur = first_ff;
          nxt_addr = first_ff;
          nxt_skip = 1'b0;
          nxt_state = S_RCTL;
        end else if (cmd_ff[`RXDD_CMD_ABORT]) begin
          cmd_take = 3'h2;
          nxt_fe = frame_mode;
          nxt_sts = `RXDD_STS_ABORT;
          nxt_first_sel = 1'b1;
          nxt_fcnt = 16'h0000;
          nxt_state = S_DONE;
        end else if (rx_take && skip_ff) begin
          // Tail of an over-long frame is dropped up to its end
          nxt_skip = ~(rx_last | rx_event);
          nxt_fcnt = 16'h0000;
        end else if (rx_take && rx_event) begin
          nxt_fe = (mode_ff == `RXDD_MODE_HDLC) || (mode_ff == `RXDD_MODE_TMB);
          nxt_sts = rx_status & sts_mask;
          nxt_fcnt = 16'h0000;
          nxt_state = S_DONE;
        end else if (rx_take) begin
          nxt_addr = dptr_ff + {19'h00000, bno_ff};
          nxt_wdata = rx_data;
          nxt_we = 1'b1;
          nxt_bno = bno_sum;
          nxt_fcnt = fcnt_sum;
          nxt_last = rx_last;
          nxt_fsts = rx_status & sts_mask;
          nxt_state = S_WDAT;
        end
      end
      S_WDAT: begin
        if (mem_ack) begin
          nxt_we = 1'b0;
          nxt_state = S_DONE;
          if (frame_mode && fcnt_ff > MAX_FRAME) begin
            nxt_fe = 1'b1;
            nxt_sts = fsts_ff | `RXDD_STS_LONG | `RXDD_STS_ABORT;
            nxt_skip = ~last_ff;
            nxt_fcnt = 16'h0000;
          end else if (frame_mode && last_ff && bno_ff == size_ff && !hold_ff) begin
            nxt_fe = 1'b0;
            nxt_sts = `RXDD_STS_OK;
            nxt_pend_fe = 1'b1;
            nxt_fcnt = 16'h0000;
          end else if (frame_mode && last_ff) begin
            nxt_fe = 1'b1;
            nxt_sts = fsts_ff;
            nxt_fcnt = 16'h0000;
          end else if (bno_ff == size_ff && hold_ff) begin
            // Frame cannot fit behind a stall
            nxt_fe = frame_mode;
            nxt_sts = `RXDD_STS_ABORT;
          end else if (bno_ff == size_ff) begin
            nxt_fe = 1'b0;
            nxt_sts = `RXDD_STS_OK;
          end else begin
            nxt_state = S_DATA;
          end
        end
      end
      S_DONE: begin
        if (!mem_ack) begin
          nxt_addr = cur_ff + STEP3;
          nxt_wdata = {fe_ff, 1'b1, 1'b0, bno_ff, sts_ff, 8'h00};
          nxt_we = 1'b1;
        end else begin
          nxt_we = 1'b0;
          nxt_state = S_IRQ;
        end
      end
      S_IRQ: begin
        nxt_ifr = fe_ff;
        nxt_ier = (sts_ff != `RXDD_STS_OK) && (sts_ff != `RXDD_STS_SHORT);
        nxt_iho = hi_ff;
        nxt_irq = fe_ff | nxt_ier | hi_ff;
        if (hold_ff && !first_sel_ff && !pend_fe_ff) begin
          nxt_state = S_PWAIT;
        end else begin
          nxt_first_sel = 1'b0;
          nxt_cur = first_sel_ff ? first_ff : next_ff;
          nxt_addr = first_sel_ff ? first_ff : next_ff;
          nxt_state = S_RCTL;
        end
      end
      S_PWAIT: begin
        if (cmd_ff != 3'h0) begin
          cmd_take = cmd_ff;
          nxt_cur = first_ff;
          nxt_addr = first_ff;
          nxt_state = S_RCTL;
        end else if (rx_take) begin
          nxt_addr = cur_ff;
          nxt_state = S_PCTL;
        end
      end
      S_PCTL: begin
        if (mem_ack) begin
          nxt_hold = mem_rdata[`RXDD_CW_HOLD];
          if (mem_rdata[`RXDD_CW_HOLD]) begin
            nxt_state = S_PWAIT;
          end else if (frame_mode) begin
            nxt_state = S_DISC;
          end else begin
            nxt_cur = next_ff;
            nxt_addr = next_ff;
            nxt_state = S_RCTL;
          end
        end
      end
      S_DISC: begin
        if (cmd_ff != 3'h0) begin
          cmd_take = cmd_ff;
          nxt_cur = first_ff;
          nxt_addr = first_ff;
          nxt_state = S_RCTL;
        end else if (rx_take && (rx_last || rx_event)) begin
          nxt_cur = next_ff;
          nxt_addr = next_ff;
          nxt_fcnt = 16'h0000;
          nxt_state = S_RCTL;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // A stall poll rereads only the control word: the next pointer stays the one held in next_ff
  always @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= S_IDLE;
      mode_ff <= CTRL_RST[1:0];
      first_ff <= 32'h0;
      ccb_ff <= 32'h0;
      cur_ff <= 32'h0;
      next_ff <= 32'h0;
      dptr_ff <= 32'h0;
      addr_ff <= 32'h0;
      wdata_ff <= 32'h0;
      we_ff <= 1'b0;
      hold_ff <= 1'b0;
      hi_ff <= 1'b0;
      size_ff <= 13'h0000;
      bno_ff <= 13'h0000;
      fcnt_ff <= 16'h0000;
      fe_ff <= 1'b0;
      last_ff <= 1'b0;
      sts_ff <= 8'h00;
      fsts_ff <= 8'h00;
      pend_fe_ff <= 1'b0;
      skip_ff <= 1'b0;
      first_sel_ff <= 1'b0;
      cmd_ff <= 3'h0;
      irq_ff <= 1'b0;
      ifr_ff <= 1'b0;
      ier_ff <= 1'b0;
      iho_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (apb_wr && paddr == `RXDD_OFF_CTRL)
        mode_ff <= pwdata[1:0];
      first_ff <= nxt_first;
      ccb_ff <= nxt_ccb;
      cur_ff <= nxt_cur;
      next_ff <= nxt_next;
      dptr_ff <= nxt_dptr;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      hold_ff <= nxt_hold;
      hi_ff <= nxt_hi;
      size_ff <= nxt_size;
      bno_ff <= nxt_bno;
      fcnt_ff <= nxt_fcnt;
      fe_ff <= nxt_fe;
      last_ff <= nxt_last;
      sts_ff <= nxt_sts;
      fsts_ff <= nxt_fsts;
      pend_fe_ff <= nxt_pend_fe;
      skip_ff <= nxt_skip;
      first_sel_ff <= nxt_first_sel;
      // A command written in the cycle it is consumed stays pending
      cmd_ff <= (cmd_ff & ~cmd_take) | cmd_set;
      irq_ff <= nxt_irq;
      ifr_ff <= nxt_ifr;
      ier_ff <= nxt_ier;
      iho_ff <= nxt_iho;
    end
  end
endmodule

// >>> dv/rxdd_engine_props.sv
// Concurrent checks on the ports of the receive descriptor engine
`timescale 1ns/1ns
module rxdd_engine_props (
  input wire clk,
  input wire rst_b,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire rx_valid,
  input wire rx_ready,
  input wire irq_valid,
  input wire irq_frame,
  input wire irq_err,
  input wire irq_host
);
  reg [3:0] wack_age_ff;
  wire wr_done = mem_req && mem_ack && mem_we;
  wire [3:0] nxt_wack_age = wr_done ? 4'h0 : (wack_age_ff == 4'hF) ? 4'hF : wack_age_ff + 4'h1;
  // Saturates so a stale write long ago never licenses an interrupt
  always @(posedge clk)
    wack_age_ff <= rst_b ? nxt_wack_age : 4'hF;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_apb_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > 8'h14)) else $error("error response does not match address");
  a_mem_req_held: assert property (mem_req && !mem_ack |=> mem_req)
    else $error("memory request dropped before acknowledge");
  a_mem_addr_stable: assert property (mem_req && !mem_ack && $past(mem_req) &&
    !$past(mem_ack) && $past(mem_req, 2) && !$past(mem_ack, 2) |-> $stable(mem_addr)
    && $stable(mem_we)) else $error("memory address moved while waiting");
  a_irq_one_cycle: assert property (irq_valid |=> !irq_valid)
    else $error("interrupt pulse longer than one cycle");
  a_irq_has_cause: assert property (irq_valid |-> irq_frame || irq_err || irq_host)
    else $error("interrupt without any flag");
  a_irq_after_write: assert property (irq_valid |-> wack_age_ff <= 4'h2)
    else $error("interrupt not right after a completion write");
  a_rx_not_busy: assert property (rx_ready |-> !mem_req)
    else $error("receive accepted during a memory access");
  a_rx_launch_write: assert property (rx_valid && rx_ready |-> ##[1:3] (mem_req || rx_ready))
    else $error("accepted word not written to memory");
  a_reset_quiet: assert property ($rose(rst_b) |-> !mem_req && !irq_valid && !rx_ready)
    else $error("activity right after reset");
  c_host_irq: cover property (irq_valid && irq_host);
  c_err_irq: cover property (irq_valid && irq_err);
  c_write_done: cover property (wr_done);
endmodule
bind rxdd_engine rxdd_engine_props rxdd_engine_props_i (.clk, .rst_b, .paddr, .psel,
  .penable, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_ack, .rx_valid,
  .rx_ready, .irq_valid, .irq_frame, .irq_err, .irq_host);

// >>> dv/rxdd_mem_model.sv
// Behavioural shared memory answering the engine's word requests
`timescale 1ns/1ns
module rxdd_mem_model (
  input wire clk,
  input wire rst_b,
  input wire slow,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output reg mem_ack,
  output reg [31:0] mem_rdata
);
  reg [31:0] mem [0:255];
  reg [1:0] wait_ff;
  // Never acks in the first request cycle: completion data settles one cycle late
  always @(posedge clk) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_ff <= 2'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_we)
        mem[mem_addr[9:2]] <= mem_wdata;
    end else if (mem_req && wait_ff == (slow ? 2'h3 : 2'h1)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[9:2]];
    end else begin
      wait_ff <= mem_req ? wait_ff + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// >>> dv/rxdd_engine_bench.sv
// Self-checking bench for the receive descriptor engine
`timescale 1ns/1ns
`include "rxdd_regs.vh"
module rxdd_engine_bench;
  reg clk, rst_b, psel, penable, pwrite, rx_valid, rx_last, slow, err;
  reg [7:0] paddr, rx_status;
  reg rx_event;
  reg [31:0] pwdata, rx_data, rd;
  reg [2:0] rx_nbytes, irq_seen;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
  wire pready, pslverr, mem_req, mem_we, mem_ack, rx_ready;
  wire irq_valid, irq_frame, irq_err, irq_host;
  integer fails, n_tests, n_irq;
  rxdd_engine #(.MAX_FRAME(16'h0010)) rxdd_engine_i (.clk, .rst_b, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .rx_valid, .rx_ready, .rx_data, .rx_nbytes, .rx_last,
    .rx_event, .rx_status, .irq_valid, .irq_frame, .irq_err, .irq_host);
  rxdd_mem_model rxdd_mem_model_i (.clk, .rst_b, .slow, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (irq_valid === 1'b1) begin
    n_irq <= n_irq + 1;
    irq_seen <= {irq_frame, irq_err, irq_host};
  end
  task finish_test;
    begin
      if (fails == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
    end
  endtask
  task send(input [31:0] d, input [2:0] nb, input last);
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_nbytes <= nb;
      rx_last <= last;
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~d;
    end
  endtask
  task wait_ready(input v);
    integer k;
    begin
      k = 0;
      while (rx_ready !== v && k < 500) begin
        @(posedge clk);
        k = k + 1;
      end
    end
  endtask
  task wait_irq(input integer n);
    integer k;
    begin
      k = 0;
      while (n_irq < n && k < 3000) begin
        @(posedge clk);
        k = k + 1;
      end
      chk(n_irq, n);
    end
  endtask
  task desc(input [31:0] a, input [31:0] cw, input [31:0] nx, input [31:0] dp);
    begin
      rxdd_mem_model_i.mem[a[9:2]] = cw;
      rxdd_mem_model_i.mem[a[9:2] + 8'h1] = nx;
      rxdd_mem_model_i.mem[a[9:2] + 8'h2] = dp;
      rxdd_mem_model_i.mem[a[9:2] + 8'h3] = 32'h0;
    end
  endtask
  function [31:0] mw(input [31:0] a);
    mw = rxdd_mem_model_i.mem[a[9:2]];
  endfunction
  task sc_regs;
    begin
      rdc(`RXDD_OFF_CTRL, `RXDD_CTRL_RST);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `RXDD_OFF_FIRST, 32'h0000_0100);
      apb(1'b1, `RXDD_OFF_CCB, 32'h0000_0300);
      rdc(`RXDD_OFF_FIRST, 32'h0000_0100);
      rdc(`RXDD_OFF_CMD, 32'h0);
    end
  endtask
  task sc_normal;
    begin
      desc(32'h100, 32'h2008_0000, 32'h140, 32'h200); // host bit, size 8
      desc(32'h140, 32'h0008_0000, 32'h180, 32'h240);
      desc(32'h180, 32'h0008_0000, 32'h1C0, 32'h280);
      desc(32'h1C0, 32'h0008_0000, 32'h100, 32'h2C0);
      apb(1'b1, `RXDD_OFF_CMD, 32'h0000_0004);
      send(32'h4433_2211, 3'h4, 1'b0);
      send(32'h0000_0055, 3'h1, 1'b1);
      wait_irq(1);
      chk(mw(32'h200), 32'h4433_2211);
      chk(mw(32'h204) & 32'hFF, 32'h55);
      chk(mw(32'h10C), 32'hC005_0000);
      chk({29'h0, irq_seen}, 32'h5);
      rdc(`RXDD_OFF_CUR, 32'h140);
    end
  endtask
  task sc_exact;
    begin
      slow = 1'b1;
      send(32'h0403_0201, 3'h4, 1'b0);
      chk(mw(32'h300), 32'h140);
      send(32'h0807_0605, 3'h4, 1'b1);
      wait_irq(2);
      chk(mw(32'h244), 32'h0807_0605);
      chk(mw(32'h14C), 32'h4008_0000);
      chk(mw(32'h18C), 32'hC000_0000);
      chk({29'h0, irq_seen}, 32'h4);
      slow = 1'b0;
    end
  endtask
  task sc_abort;
    begin
      send(32'hA1A2_A3A4, 3'h4, 1'b0);
      wait_ready(1'b1);
      rxdd_mem_model_i.mem[8'h43] = 32'h1234_5678;
      apb(1'b1, `RXDD_OFF_CMD, 32'h0000_0002);
      wait_irq(3);
      chk(mw(32'h2C0), 32'hA1A2_A3A4);
      chk(mw(32'h1CC), 32'hC004_0200);
      chk({29'h0, irq_seen}, 32'h6);
      rdc(`RXDD_OFF_CUR, 32'h100);
    end
  endtask
  task sc_init;
    begin
      wait_ready(1'b1);
      send(32'hB1B2_B3B4, 3'h4, 1'b0);
      wait_ready(1'b1);
      apb(1'b1, `RXDD_OFF_CMD, 32'h0000_0004);
      wait_ready(1'b0);
      wait_ready(1'b1);
      chk(mw(32'h10C), 32'h1234_5678);
      chk(n_irq, 3);
      rdc(`RXDD_OFF_CUR, 32'h100);
    end
  endtask
  task sc_event;
    begin
      desc(32'h140, 32'h4008_0000, 32'h180, 32'h240); // stall bit, size 8
      apb(1'b1, `RXDD_OFF_CTRL, 32'h0000_0002);
      rx_event <= 1'b1;
      rx_status <= 8'hFF;
      send(32'h0, 3'h1, 1'b0);
      rx_event <= 1'b0;
      rx_status <= 8'h00;
      wait_irq(4);
      chk(mw(32'h10C), 32'h4000_2300);
      chk({29'h0, irq_seen}, 32'h3);
    end
  endtask
  task sc_hold;
    begin
      send(32'hC1C2_C3C4, 3'h4, 1'b0);
      send(32'hC5C6_C7C8, 3'h4, 1'b1);
      wait_irq(5);
      chk(mw(32'h244), 32'hC5C6_C7C8);
      chk(mw(32'h14C), 32'h4008_0200);
      chk({29'h0, irq_seen}, 32'h2);
      send(32'hD1D2_D3D4, 3'h4, 1'b0);
      wait_ready(1'b0);
      wait_ready(1'b1);
      chk(n_irq, 5);
      rdc(`RXDD_OFF_CUR, 32'h140);
      // Stall released only after the first poll has completed
      rxdd_mem_model_i.mem[8'h50] = 32'h0008_0000;
      send(32'hE1E2_E3E4, 3'h4, 1'b0);
      send(32'hF1F2_F3F4, 3'h4, 1'b0);
      wait_ready(1'b0);
      wait_ready(1'b1);
      chk(mw(32'h280), 32'hF1F2_F3F4);
      rdc(`RXDD_OFF_CUR, 32'h180);
    end
  endtask
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_valid = 1'b0;
    rx_data = 32'h0;
    rx_nbytes = 3'h0;
    rx_last = 1'b0;
    rx_event = 1'b0;
    rx_status = 8'h00;
    slow = 1'b0;
    fails = 0;
    n_tests = 0;
    n_irq = 0;
    irq_seen = 3'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    sc_regs;
    sc_normal;
    sc_exact;
    sc_abort;
    sc_init;
    sc_event;
    sc_hold;
    finish_test;
  end
  initial begin
    #400000;
    fails = fails + 1;
    finish_test;
  end
endmodule
